// ### hdl/ddr_cfg_pkg.sv
package ddr_cfg_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_OPTIONS  = 8'h20;
	localparam logic [7:0] IDX_REFRESH  = 8'h30;
	localparam logic [7:0] IDX_UPPER    = 8'h38;
	localparam logic [7:0] IDX_BANK0    = 8'h40;
	localparam logic [7:0] IDX_TIMING0  = 8'h80;
	localparam logic [7:0] IDX_TIMING1  = 8'h81;
	localparam logic [7:0] IDX_CLKPHASE = 8'h82;
	localparam logic [7:0] IDX_WRPHASE  = 8'h83;
	localparam logic [7:0] IDX_STATUS   = 8'h84;
	localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

	// Field positions as LSB of the 32-bit word (bit 0 of the word is the LSB)
	localparam int OPT_ENABLE = 31;
	localparam int OPT_ECC    = 28;
	localparam int OPT_PAGE   = 26;
	localparam int OPT_UIO    = 22;
	localparam int OPT_POLICY = 21;
	localparam int T0_XCS     = 30;
	localparam int T0_CL      = 23;
	localparam int T0_TRP     = 18;
	localparam int T0_TRTP    = 16;
	localparam int T0_TWTR    = 7;
	localparam int T0_EXT     = 5;
	localparam int T0_RFC     = 2;
	localparam int T0_RCD     = 0;
	localparam int T1_CYCLE   = 30;
	localparam int T1_STAGE   = 22;
	localparam int T1_TUNE    = 0;
	localparam int PH_SHIFT   = 30;
	localparam int B0_BASE    = 23;
	localparam int B0_SIZE    = 17;
	localparam int B0_MODE    = 13;
	localparam int B0_ENABLE  = 0;
	localparam int RT_INT     = 19;
	localparam int UA_BITS    = 0;

	// Encoding offsets: field code plus base gives clocks
	localparam logic [4:0] TRP_BASE  = 5'h01;
	localparam logic [4:0] TRTP_BASE = 5'h02;
	localparam logic [4:0] TRFC_BASE = 5'h06;
	localparam logic [4:0] TRCD_BASE = 5'h01;
	localparam logic [4:0] TWTR_LONG = 5'h02;
	localparam logic [4:0] TWTR_SHORT = 5'h01;
	localparam logic [4:0] XCS_GAP   = 5'h02;
	localparam logic [4:0] PIPE_GAP  = 5'h02;
	localparam logic [3:0] SYNC_LAT  = 4'h2;
	localparam logic [2:0] MODE_STD  = 3'h2;
	localparam logic [1:0] UIO_ACTIVE = 2'h0;
	localparam logic [1:0] ECC_NONE  = 2'h0;
	localparam int PRE_ALL_BIT = 10;

	// Command codes as {ras_n, cas_n, we_n}
	localparam logic [2:0] CMD_NOP = 3'h7;
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_RD  = 3'h5;
	localparam logic [2:0] CMD_WR  = 3'h4;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_REF = 3'h1;

	localparam int AGE_ACT = 0;
	localparam int AGE_RW  = 1;
	localparam int AGE_PRE = 2;
	localparam int AGE_REF = 3;

	typedef struct packed {
		logic        cs;
		logic [1:0]  ba;
		logic [12:0] row;
		logic [9:0]  col;
	} split_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_PRE  = 5'h02,
		ST_ACT  = 5'h04,
		ST_RW   = 5'h08,
		ST_REF  = 5'h10
	} state_t;

endpackage : ddr_cfg_pkg

// ### hdl/timer_if.sv
`timescale 1ns/10ps
interface timer_if #(parameter int W = 5);
	logic         load;
	logic [W-1:0] value;
	logic         expired;
	modport owner (output load, output value, input expired);
	modport timer (input load, input value, output expired);
endinterface : timer_if

// ### hdl/gap_timer.sv
`timescale 1ns/10ps
module gap_timer (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Spacing request
	timer_if.timer   gap
);
	logic [$bits(gap.value)-1:0] count;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			count <= '0;
		else if (gap.load)
			count <= gap.value;
		else if (count != '0)
			count <= count - 1'b1;
	end

	assign gap.expired = (count == '0) && !gap.load;
endmodule : gap_timer

// ### hdl/refresh_pacer.sv
`timescale 1ns/10ps
module refresh_pacer #(
	parameter int UNIT = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Interval in units, run level, tick out
	timer_if.timer   pace
);
	localparam int UW = $clog2(UNIT + 1);
	localparam logic [UW-1:0] UNIT_LAST = UW'(UNIT - 1);
	logic [UW-1:0]                unit_cnt;
	logic [$bits(pace.value)-1:0] int_cnt;
	logic                         unit_tick;
	logic                         tick;

	// Prescaler keeps the interval field short at the cost of granularity
	assign unit_tick = pace.load && (unit_cnt == UNIT_LAST);
	assign tick = unit_tick && (pace.value != '0) && (int_cnt + 1'b1 >= pace.value);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			unit_cnt <= '0;
			int_cnt  <= '0;
		end else if (!pace.load) begin
			unit_cnt <= '0;
			int_cnt  <= '0;
		end else begin
			unit_cnt <= unit_tick ? '0 : unit_cnt + 1'b1;
			if (tick)
				int_cnt <= '0;
			else if (unit_tick)
				int_cnt <= int_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			pace.expired <= 1'b0;
		else
			pace.expired <= tick;
	end

	logic [15:0] since_tick;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			since_tick <= '0;
		else if (pace.expired || !pace.load)
			since_tick <= 16'h0001;
		else
			since_tick <= since_tick + 1'b1;
	end

	AST_REFRESH_SPACING: assert property (@(posedge clk_sys) disable iff (rst)
		pace.expired && $stable(pace.value) && $past(pace.load) && $past(pace.expired, 20) == 1'b0
		|-> since_tick >= 16'(UNIT)) else $error("refresh ticks closer than one unit");
endmodule : refresh_pacer

// ### hdl/ddr_bank_ctrl.sv
`timescale 1ns/10ps
module ddr_bank_ctrl import ddr_cfg_pkg::*; #(
	parameter int OPEN_LIMIT   = 2,
	parameter int REFRESH_UNIT = 8
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Register bus
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Memory requests
	input  wire logic        req_valid,
	input  wire logic        req_write,
	input  wire logic [35:0] req_addr,
	input  wire logic [63:0] req_wdata,
	output logic             req_ready,
	output logic             req_miss,
	output logic             rd_valid,
	output logic      [63:0] rd_data,
	// Memory pins
	output logic      [1:0]  mem_cs_n,
	output logic             mem_ras_n,
	output logic             mem_cas_n,
	output logic             mem_we_n,
	output logic      [1:0]  mem_ba,
	output logic      [12:0] mem_a,
	output logic      [63:0] mem_dq_out,
	output logic             mem_dq_oe,
	input  wire logic [63:0] mem_dq_in,
	output logic             mem_dqs_en,
	// Capture and clock tuning
	output logic      [1:0]  read_sample_cycle,
	output logic      [1:0]  read_sample_stage,
	output logic      [8:0]  read_clock_tuning,
	output logic      [1:0]  write_clock_phase,
	output logic      [1:0]  write_data_clock_phase,
	output logic             error_check_on
);
	logic [31:0] controller_options, refresh_timer, upper_address_base, bank_zero_config;
	logic [31:0] command_timing_zero, read_timing_one, clock_phase_timing;
	logic [31:0] write_data_clock_timing, next_readdata, status_word;
	logic [7:0]  idx;
	logic        bus_ack, bus_we;
	logic        sel_opt, sel_rtr, sel_uab, sel_b0, sel_t0, sel_t1, sel_ck, sel_wd, sel_st;
	logic [2:0]  written;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		for (int i = 0; i < 4; i++)
			merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
	endfunction : merge

	function automatic logic [4:0] clocks(input logic [2:0] enc, input logic [4:0] base);
		return 5'(enc) + base;
	endfunction : clocks

	function automatic split_t split(input logic [35:0] a, input logic [2:0] mode);
		split_t s;
		s.col = a[12:3];
		s.cs  = a[28];
		if (mode == MODE_STD) begin
			s.ba  = a[14:13];
			s.row = a[27:15];
		end else begin
			s.row = a[25:13];
			s.ba  = a[27:26];
		end
		return s;
	endfunction : split

	function automatic logic [2:0] popcount(input logic [3:0] v);
		return 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
	endfunction : popcount

	// Bus slave: one wait cycle per access, answer at the second edge
	assign idx = avs_address[9:2];
	assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
	assign bus_we = avs_write & bus_ack;
	assign sel_opt = idx == IDX_OPTIONS;
	assign sel_rtr = idx == IDX_REFRESH;
	assign sel_uab = idx == IDX_UPPER;
	assign sel_b0  = idx == IDX_BANK0;
	assign sel_t0  = idx == IDX_TIMING0;
	assign sel_t1  = idx == IDX_TIMING1;
	assign sel_ck  = idx == IDX_CLKPHASE;
	assign sel_wd  = idx == IDX_WRPHASE;
	assign sel_st  = idx == IDX_STATUS;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			bus_ack <= 1'b0;
		else
			bus_ack <= (avs_read | avs_write) & ~bus_ack;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			controller_options      <= RESET_VALUE;
			refresh_timer           <= RESET_VALUE;
			upper_address_base      <= RESET_VALUE;
			bank_zero_config        <= RESET_VALUE;
			command_timing_zero     <= RESET_VALUE;
			read_timing_one         <= RESET_VALUE;
			clock_phase_timing      <= RESET_VALUE;
			write_data_clock_timing <= RESET_VALUE;
			written                 <= 3'h0;
		end else if (bus_we) begin
			if (sel_opt) controller_options <= merge(controller_options, avs_writedata, avs_byteenable);
			if (sel_rtr) refresh_timer <= merge(refresh_timer, avs_writedata, avs_byteenable);
			if (sel_uab) upper_address_base <= merge(upper_address_base, avs_writedata, avs_byteenable);
			if (sel_b0) bank_zero_config <= merge(bank_zero_config, avs_writedata, avs_byteenable);
			if (sel_t0) command_timing_zero <= merge(command_timing_zero, avs_writedata, avs_byteenable);
			if (sel_t1) read_timing_one <= merge(read_timing_one, avs_writedata, avs_byteenable);
			if (sel_ck) clock_phase_timing <= merge(clock_phase_timing, avs_writedata, avs_byteenable);
			if (sel_wd) write_data_clock_timing <= merge(write_data_clock_timing, avs_writedata,
				avs_byteenable);
			written <= written | {sel_rtr, sel_t0, sel_b0};
		end
	end

	always_comb begin
		next_readdata = 32'h0000_0000;
		if (sel_opt) next_readdata = controller_options;
		else if (sel_rtr) next_readdata = refresh_timer;
		else if (sel_uab) next_readdata = upper_address_base;
		else if (sel_b0) next_readdata = bank_zero_config;
		else if (sel_t0) next_readdata = command_timing_zero;
		else if (sel_t1) next_readdata = read_timing_one;
		else if (sel_ck) next_readdata = clock_phase_timing;
		else if (sel_wd) next_readdata = write_data_clock_timing;
		else if (sel_st) next_readdata = status_word;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read && !bus_ack)
			avs_readdata <= next_readdata;
	end

	// Decoded configuration
	logic        cfg_ready, page_mgr, policy_lru, hit;
	logic [4:0]  trp, trtp, trfc, trcd, twtr;
	logic [1:0]  uio;
	logic [8:0]  base_mask;
	logic [3:0]  lat;
	split_t      tgt;

	assign cfg_ready = (&written) && controller_options[OPT_ENABLE]
		&& bank_zero_config[B0_ENABLE];
	assign page_mgr   = controller_options[OPT_PAGE];
	assign policy_lru = controller_options[OPT_POLICY];
	assign uio        = controller_options[OPT_UIO +: 2];
	assign error_check_on = controller_options[OPT_ECC +: 2] != ECC_NONE;
	assign trp  = clocks({1'b0, command_timing_zero[T0_TRP +: 2]}, TRP_BASE);
	assign trtp = clocks({1'b0, command_timing_zero[T0_TRTP +: 2]}, TRTP_BASE);
	assign twtr = command_timing_zero[T0_TWTR] ? TWTR_LONG : TWTR_SHORT;
	assign trfc = clocks(command_timing_zero[T0_RFC +: 3], TRFC_BASE)
		+ 5'(command_timing_zero[T0_EXT +: 2]);
	assign trcd = clocks({1'b0, command_timing_zero[T0_RCD +: 2]}, TRCD_BASE);
	assign read_sample_cycle = read_timing_one[T1_CYCLE +: 2];
	assign read_sample_stage = read_timing_one[T1_STAGE +: 2];
	assign read_clock_tuning = read_timing_one[T1_TUNE +: 9];
	assign write_clock_phase = clock_phase_timing[PH_SHIFT +: 2];
	assign write_data_clock_phase = write_data_clock_timing[PH_SHIFT +: 2];
	assign lat = 4'(command_timing_zero[T0_CL +: 2]) + 4'(read_sample_cycle)
		+ 4'(read_sample_stage) + SYNC_LAT;

	// Window: size code n of 1 and up spans 4MB << n, so n-1 low base bits are ignored; code 0 spans 8MB
	assign base_mask = (bank_zero_config[B0_SIZE +: 3] == 3'h0) ? 9'h1ff
		: 9'h1ff << (bank_zero_config[B0_SIZE +: 3] - 3'h1);
	assign hit = (req_addr[35:32] == upper_address_base[UA_BITS +: 4])
		&& ((req_addr[31:23] & base_mask) == (bank_zero_config[B0_BASE +: 9] & base_mask));
	assign tgt = split(req_addr, bank_zero_config[B0_MODE +: 3]);

	// Command sequencer
	state_t      state, next_state;
	logic [3:0]  open_bank;
	logic [12:0] open_row [4];
	logic [1:0]  mru, pre_bank, next_pre_bank, victim;
	logic        pre_all, next_pre_all, refresh_pending, miss_take, last_wr, last_cs;
	logic        rw_ok, rtp_ok, is_rd, is_wr;
	logic [4:0]  age [4];
	logic [15:0] rd_pipe;
	logic [63:0] dq_s1, dq_s2;
	logic [2:0]  cmd;

	timer_if #(.W(5))  gap ();
	timer_if #(.W(11)) pace ();

	gap_timer u_gap (
		.clk_sys (clk_sys),
		.rst     (rst),
		.gap     (gap.timer)
	);

	refresh_pacer #(.UNIT(REFRESH_UNIT)) u_pace (
		.clk_sys (clk_sys),
		.rst     (rst),
		.pace    (pace.timer)
	);

	assign pace.load  = cfg_ready;
	assign pace.value = refresh_timer[RT_INT +: 11];
	assign gap.load   = state != ST_IDLE;
	assign gap.value  = (state == ST_PRE) ? trp - PIPE_GAP
		: (state == ST_ACT) ? trcd - PIPE_GAP
		: (state == ST_REF) ? trfc - PIPE_GAP : 5'h00;

	// Victim: lowest open bank other than the most recently used, or lowest open one otherwise
	always_comb begin
		victim = mru;
		for (int i = 3; i >= 0; i--)
			if (open_bank[i] && (!policy_lru || 2'(i) != mru))
				victim = 2'(i);
	end

	// Widened so a saturated age cannot wrap and stall the sequencer
	assign rtp_ok = 6'(age[AGE_RW]) + 6'(PIPE_GAP) >= 6'(trtp);
	assign rw_ok = req_write
		? (!(last_wr && last_cs != tgt.cs && command_timing_zero[T0_XCS])
			|| 6'(age[AGE_RW]) + 6'(PIPE_GAP) >= 6'(XCS_GAP))
		: (!last_wr || 6'(age[AGE_RW]) + 6'(PIPE_GAP) >= 6'(twtr));

	always_comb begin
		next_state    = ST_IDLE;
		next_pre_all  = 1'b0;
		next_pre_bank = tgt.ba;
		miss_take     = 1'b0;
		case (state)
			ST_IDLE: if (cfg_ready && gap.expired) begin
				if (refresh_pending || (!page_mgr && open_bank != 4'h0)) begin
					next_pre_all = 1'b1;
					if (open_bank != 4'h0)
						next_state = rtp_ok ? ST_PRE : ST_IDLE;
					else
						next_state = ST_REF;
				end else if (req_valid && !hit) begin
					miss_take = 1'b1;
				end else if (req_valid) begin
					if (open_bank[tgt.ba] && open_row[tgt.ba] != tgt.row)
						next_state = rtp_ok ? ST_PRE : ST_IDLE;
					else if (open_bank[tgt.ba])
						next_state = rw_ok ? ST_RW : ST_IDLE;
					else if (32'(popcount(open_bank)) >= OPEN_LIMIT) begin
						next_pre_bank = victim;
						next_state = rtp_ok ? ST_PRE : ST_IDLE;
					end else
						next_state = ST_ACT;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	assign req_ready = (state == ST_RW) || miss_take;
	assign req_miss  = miss_take;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state    <= ST_IDLE;
			pre_all  <= 1'b0;
			pre_bank <= 2'h0;
		end else begin
			state <= next_state;
			if (state == ST_IDLE) begin
				pre_all  <= next_pre_all;
				pre_bank <= next_pre_bank;
			end
		end
	end

	// Command pins; activate and precharge reach both ranks
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			{mem_ras_n, mem_cas_n, mem_we_n} <= CMD_NOP;
			mem_cs_n <= 2'h3;
			mem_ba   <= 2'h0;
			mem_a    <= 13'h0000;
		end else begin
			{mem_ras_n, mem_cas_n, mem_we_n} <= CMD_NOP;
			mem_cs_n <= 2'h3;
			case (state)
				ST_PRE: begin
					{mem_ras_n, mem_cas_n, mem_we_n} <= CMD_PRE;
					mem_cs_n <= 2'h0;
					mem_ba   <= pre_bank;
					mem_a    <= 13'(pre_all) << PRE_ALL_BIT;
				end
				ST_ACT: begin
					{mem_ras_n, mem_cas_n, mem_we_n} <= CMD_ACT;
					mem_cs_n <= 2'h0;
					mem_ba   <= tgt.ba;
					mem_a    <= tgt.row;
				end
				ST_RW: begin
					{mem_ras_n, mem_cas_n, mem_we_n} <= req_write ? CMD_WR : CMD_RD;
					mem_cs_n <= tgt.cs ? 2'h1 : 2'h2;
					mem_ba   <= tgt.ba;
					mem_a    <= {3'h0, tgt.col};
				end
				ST_REF: begin
					{mem_ras_n, mem_cas_n, mem_we_n} <= CMD_REF;
					mem_cs_n <= 2'h0;
				end
				default: ;
			endcase
		end
	end

	// Open page tracking; refresh pending set wins over its clear
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			open_bank       <= 4'h0;
			mru             <= 2'h0;
			refresh_pending <= 1'b0;
			last_wr         <= 1'b0;
			last_cs         <= 1'b0;
			for (int i = 0; i < 4; i++)
				open_row[i] <= 13'h0000;
		end else begin
			refresh_pending <= pace.expired || (refresh_pending && state != ST_REF);
			if (state == ST_PRE)
				open_bank <= pre_all ? 4'h0 : open_bank & ~(4'h1 << pre_bank);
			if (state == ST_ACT) begin
				open_bank[tgt.ba] <= 1'b1;
				open_row[tgt.ba]  <= tgt.row;
				mru               <= tgt.ba;
			end
			if (state == ST_RW) begin
				mru     <= tgt.ba;
				last_wr <= req_write;
				last_cs <= tgt.cs;
			end
		end
	end

	// Cycles since each kind of command, saturating
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 4; i++)
				age[i] <= 5'h1f;
		end else begin
			for (int i = 0; i < 4; i++)
				if (age[i] != 5'h1f)
					age[i] <= age[i] + 5'h01;
			if (state == ST_ACT) age[AGE_ACT] <= 5'h00;
			if (state == ST_RW)  age[AGE_RW]  <= 5'h00;
			if (state == ST_PRE) age[AGE_PRE] <= 5'h00;
			if (state == ST_REF) age[AGE_REF] <= 5'h00;
		end
	end

	// Data path; pins pass two flops before capture
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dq_s1      <= 64'h0;
			dq_s2      <= 64'h0;
			rd_pipe    <= 16'h0000;
			rd_valid   <= 1'b0;
			rd_data    <= 64'h0;
			mem_dq_out <= 64'h0;
			mem_dq_oe  <= 1'b0;
		end else begin
			dq_s1    <= mem_dq_in;
			dq_s2    <= dq_s1;
			rd_pipe  <= {rd_pipe[14:0], state == ST_RW && !req_write};
			rd_valid <= rd_pipe[lat];
			if (rd_pipe[lat])
				rd_data <= dq_s2;
			if (state == ST_RW && req_write)
				mem_dq_out <= req_wdata;
			mem_dq_oe <= (uio == UIO_ACTIVE) ? (state == ST_RW && req_write)
				: (rd_pipe == 16'h0000);
		end
	end

	assign mem_dqs_en = (uio == UIO_ACTIVE) ? 1'b1 : mem_dq_oe;
	assign status_word = {24'h0, cfg_ready, refresh_pending, state == ST_IDLE, 1'b0, open_bank};

	assign cmd   = {mem_ras_n, mem_cas_n, mem_we_n};
	assign is_rd = cmd == CMD_RD;
	assign is_wr = cmd == CMD_WR;

	AST_NO_CMD_WHEN_OFF: assert property (@(posedge clk_sys) disable iff (rst)
		$past(!cfg_ready) && $past(!cfg_ready, 2) |-> cmd == CMD_NOP)
		else $error("command issued while controller off");
	AST_CFG_BEFORE_CMD: assert property (@(posedge clk_sys) disable iff (rst)
		cmd != CMD_NOP |-> $past(&written, 2)) else $error("command before configuration");
	AST_PRE_TO_ACT: assert property (@(posedge clk_sys) disable iff (rst)
		cmd == CMD_ACT |-> age[AGE_PRE] >= trp) else $error("activate too soon after precharge");
	AST_RW_TO_PRE: assert property (@(posedge clk_sys) disable iff (rst)
		cmd == CMD_PRE |-> age[AGE_RW] >= trtp) else $error("precharge too soon after access");
	AST_WR_TO_RD: assert property (@(posedge clk_sys) disable iff (rst)
		is_rd && $past(last_wr) |-> $past(age[AGE_RW]) >= twtr - 5'h01)
		else $error("read too soon after write");
	AST_REF_TO_ACT: assert property (@(posedge clk_sys) disable iff (rst)
		cmd == CMD_ACT |-> age[AGE_REF] >= trfc) else $error("activate too soon after refresh");
	AST_ACT_TO_COL: assert property (@(posedge clk_sys) disable iff (rst)
		is_rd || is_wr |-> age[AGE_ACT] >= trcd) else $error("column command too soon");
	AST_CROSS_CS_GAP: assert property (@(posedge clk_sys) disable iff (rst)
		is_wr && $past(last_wr) && command_timing_zero[T0_XCS]
		&& (mem_cs_n[0] != $past(last_cs))
		|-> $past(age[AGE_RW]) >= XCS_GAP - 5'h01)
		else $error("no gap between writes across selects");
	AST_READ_RETURNS: assert property (@(posedge clk_sys) disable iff (rst)
		is_rd && $stable(read_timing_one) |-> ##[1:12] rd_valid)
		else $error("read data never captured");

	COV_REFRESH: cover property (@(posedge clk_sys) disable iff (rst) cmd == CMD_REF);
	COV_READ: cover property (@(posedge clk_sys) disable iff (rst) is_rd ##[1:12] rd_valid);
	COV_PAGE_MISS: cover property (@(posedge clk_sys) disable iff (rst)
		cmd == CMD_PRE && mem_a[PRE_ALL_BIT] == 1'b0);
	COV_MISS: cover property (@(posedge clk_sys) disable iff (rst) req_miss);
endmodule : ddr_bank_ctrl

// ### verification/ddr_mem_model.sv
`timescale 1ns/10ps
module ddr_mem_model import ddr_cfg_pkg::*; #(
	parameter int CL = 3
) (
	// Clock
	input  wire logic        clk_sys,
	// Command pins
	input  wire logic [1:0]  mem_cs_n,
	input  wire logic        mem_ras_n,
	input  wire logic        mem_cas_n,
	input  wire logic        mem_we_n,
	input  wire logic [1:0]  mem_ba,
	input  wire logic [12:0] mem_a,
	// Data pins
	input  wire logic [63:0] mem_dq_out,
	input  wire logic        mem_dq_oe,
	output logic      [63:0] mem_dq_in
);
	logic [63:0] store [int];
	logic [12:0] open_row [4];
	logic [2:0]  cmd;
	int          key = 0;
	int          cnt = 99;
	assign cmd = {mem_ras_n, mem_cas_n, mem_we_n};
	initial mem_dq_in = '0;
	always @(posedge clk_sys) begin
		cnt++;
		if (mem_cs_n != 2'b11 && cmd == CMD_ACT)
			open_row[mem_ba] <= mem_a;
		if (mem_cs_n != 2'b11 && (cmd == CMD_RD || cmd == CMD_WR)) begin
			key = {mem_ba, open_row[mem_ba], mem_a[9:0]};
			cnt = 0;
		end
		if (mem_dq_oe === 1'b1)
			store[key] = mem_dq_out;
		// Outside the read burst the bus floats, so stale data must not look valid
		if (cnt >= CL && cnt <= CL + 5 && store.exists(key))
			mem_dq_in <= store[key];
		else
			mem_dq_in <= ~mem_dq_in;
	end
endmodule : ddr_mem_model

// ### verification/ddr_sdram_bank_timing_config_tb.sv
`timescale 1ns/10ps
module ddr_sdram_bank_timing_config_tb import ddr_cfg_pkg::*;;
	logic        clk_sys, rst, avs_read, avs_write, avs_waitrequest, req_valid, req_write;
	logic        req_ready, req_miss, rd_valid, mem_dq_oe, mem_dqs_en, error_check_on;
	logic        mem_ras_n, mem_cas_n, mem_we_n, ok, ms;
	logic [9:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [35:0] req_addr;
	logic [63:0] req_wdata, rd_data, mem_dq_out, mem_dq_in;
	logic [1:0]  mem_cs_n, mem_ba, read_sample_cycle, read_sample_stage, write_clock_phase;
	logic [1:0]  write_data_clock_phase;
	logic [12:0] mem_a;
	logic [8:0]  read_clock_tuning;
	logic [2:0]  cmd;
	int          fails, n_tests, cyc, n_cmd, n_ref, t_ref, t_wr, i, k;
	int          t_act[4], t_rw[4], t_pre[4], g[5];
	localparam logic [9:0]  ra[8] = '{10'h200, 10'h204, 10'h208, 10'h20c, 10'h0c0, 10'h0e0,
		10'h100, 10'h080};
	localparam logic [31:0] rv[8] = '{32'hc18a40be, 32'h40400198, 32'h40000000, 32'h0,
		32'h06180000, 32'h0, 32'h000c4001, 32'h86200000};
	localparam logic [35:0] ma[3] = '{36'h0_0000_0040, 36'h0_0000_a048, 36'h0_0001_0040};
	localparam logic [63:0] md[3] = '{64'h0123_4567_89ab_cdef, 64'hfedc_ba98_7654_3210,
		64'h5a5a_0ff0_a5a5_f00f};
	assign cmd = {mem_ras_n, mem_cas_n, mem_we_n};
	always #5 clk_sys = ~clk_sys;

	ddr_bank_ctrl #(.REFRESH_UNIT(1)) uut (.clk_sys(clk_sys), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .req_valid(req_valid), .req_write(req_write),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .req_miss(req_miss),
		.rd_valid(rd_valid), .rd_data(rd_data), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n),
		.mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_a(mem_a),
		.mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in),
		.mem_dqs_en(mem_dqs_en), .read_sample_cycle(read_sample_cycle),
		.read_sample_stage(read_sample_stage), .read_clock_tuning(read_clock_tuning),
		.write_clock_phase(write_clock_phase), .write_data_clock_phase(write_data_clock_phase),
		.error_check_on(error_check_on));
	ddr_mem_model mem (.clk_sys(clk_sys), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n),
		.mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_a(mem_a),
		.mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in));

	function int mn(input int a, input int b);
		return a < b ? a : b;
	endfunction : mn
	// Smallest spacing seen between command kinds; per bank except refresh to activate and write to read
	always @(posedge clk_sys) begin
		cyc++;
		if (mem_cs_n != 2'b11 && cmd != CMD_NOP) begin
			n_cmd++;
			if (cmd == CMD_REF) begin
				n_ref++;
				t_ref = cyc;
			end
			if (cmd == CMD_ACT) begin
				g[0] = mn(g[0], cyc - t_ref);
				g[4] = mn(g[4], cyc - t_pre[mem_ba]);
				t_act[mem_ba] = cyc;
			end
			if (cmd == CMD_RD || cmd == CMD_WR) begin
				g[1] = mn(g[1], cyc - t_act[mem_ba]);
				if (cmd == CMD_RD)
					g[3] = mn(g[3], cyc - t_wr);
				else
					t_wr = cyc;
				t_rw[mem_ba] = cyc;
			end
			if (cmd == CMD_PRE)
				for (int b = 0; b < 4; b++)
					if (mem_a[PRE_ALL_BIT] || b == mem_ba) begin
						g[2] = mn(g[2], cyc - t_rw[b]);
						t_pre[b] = cyc;
					end
		end
	end

	task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask : chk
	task end_sim;
		if (fails == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		i = 0;
		do begin
			@(posedge clk_sys);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 20);
		q = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		if (avs_waitrequest !== 1'b0) begin
			fails++;
			end_sim;
		end
	endtask : bus
	task req(input logic w, input logic [35:0] a, input logic [63:0] d, input int lim);
		@(posedge clk_sys);
		req_valid <= 1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		i = 0;
		do begin
			@(posedge clk_sys);
			i++;
		end while (req_ready !== 1'b1 && i < lim);
		ok = req_ready === 1'b1;
		ms = req_miss === 1'b1;
		req_valid <= 0;
	endtask : req
	task cfg(input logic en);
		for (k = 0; k < 8; k++)
			bus(1, ra[k], (k == 7 && !en) ? rv[k] & 32'h7fff_ffff : rv[k]);
	endtask : cfg

	initial begin
		{clk_sys, avs_read, avs_write, req_valid, req_write} = '0;
		{avs_address, avs_writedata, req_addr, req_wdata} = '0;
		{fails, n_tests, cyc, n_cmd, n_ref} = '0;
		t_ref = -999;
		t_wr = -999;
		t_act = '{4{-999}};
		t_rw = '{4{-999}};
		t_pre = '{4{-999}};
		g = '{999, 999, 999, 999, 999};
		rst = 1;
		repeat (16) @(posedge clk_sys);
		rst <= 0;
		cfg(0);
		for (k = 0; k < 7; k++) begin
			bus(0, ra[k], 0);
			chk("register", q, rv[k]);
		end
		bus(0, 10'h3fc, 32'h1);
		chk("unmapped", q, 0);
		bus(0, 10'h210, 0);
		chk("status_off", q[7], 0);
		req(1, ma[0], md[0], 60);
		chk("ready_before_enable", ok, 0);
		chk("commands_before_enable", n_cmd, 0);
		@(posedge clk_sys);
		rst <= 1;
		@(posedge clk_sys);
		rst <= 0;
		bus(0, 10'h200, 0);
		chk("reset_value", q, 0);
		cfg(1);
		bus(0, 10'h210, 0);
		chk("status_ready", q[7], 1);
		chk("sample_cycle", read_sample_cycle, 2'b01);
		chk("sample_stage", read_sample_stage, 2'b01);
		chk("clock_tuning", read_clock_tuning, 9'h198);
		chk("write_phase", {write_clock_phase, write_data_clock_phase}, 4'h4);
		chk("error_check", error_check_on, 0);
		chk("strobe_switching", mem_dqs_en, 1);
		for (k = 0; k < 3; k++) begin
			req(1, ma[k], md[k], 200);
			chk("write_taken", {ok, ms}, 2'b10);
		end
		for (k = 0; k < 3; k++) begin
			req(0, ma[k], 0, 200);
			chk("read_taken", {ok, ms}, 2'b10);
			for (i = 0; i < 40 && rd_valid !== 1'b1; i++)
				@(posedge clk_sys);
			chk("read_valid", rd_valid, 1);
			chk("read_data", rd_data, md[k]);
		end
		req(0, 36'h0_1000_0000, 0, 200);
		chk("miss_size", {ok, ms}, 2'b11);
		req(0, 36'h1_0000_0000, 0, 200);
		chk("miss_upper", {ok, ms}, 2'b11);
		repeat (420) @(posedge clk_sys);
		chk("refresh_count", n_ref >= 2, 1);
		chk("ref_to_act", g[0] >= 14, 1);
		chk("act_to_col", g[1] >= 3, 1);
		chk("col_to_pre", g[2] >= 4, 1);
		chk("wr_to_rd", g[3] >= 2, 1);
		chk("pre_to_act", g[4] >= 3, 1);
		end_sim;
	end
	initial begin
		#200000;
		fails++;
		end_sim;
	end
endmodule : ddr_sdram_bank_timing_config_tb
